// ==== logic/ues_pkg.sv ====
// Package for the USB device endpoint status block: register map, field positions and types.
// Assumes a 100 MHz core clock and one AHB-Lite master reaching the registers.
package ues_pkg;

	localparam int NUM_EP = 8;
	localparam int CLK_MHZ = 100;

	// Register byte offsets; each register is one aligned 32-bit word.
	localparam logic [11:0] OFF_MASK = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_CLEAR = 12'h008;
	localparam logic [11:0] OFF_EPRST = 12'h00c;
	localparam logic [11:0] OFF_CTRL = 12'h010;
	localparam logic [11:0] OFF_CSR0 = 12'h020;

	// Bus-event bit positions shared by status, clear and mask.
	localparam int ST_SUSP = 8;
	localparam int ST_RSM = 9;
	localparam int ST_EXT = 10;
	localparam int ST_SOF = 11;
	localparam int ST_BRST = 12;
	localparam int ST_WAKE = 13;
	localparam logic [31:0] MASK_RESET = 32'h0000_0200;

	// Control register bit.
	localparam int CTRL_RWE = 0;

	// Endpoint control/status field positions.
	localparam int CS_TXC = 0;
	localparam int CS_BK0 = 1;
	localparam int CS_SETUP = 2;
	localparam int CS_STALL = 3;
	localparam int CS_TXRDY = 4;
	localparam int CS_HALT = 5;
	localparam int CS_BK1 = 6;
	localparam int CS_DIR = 7;
	localparam int CS_KIND_LO = 8;
	localparam int CS_TGL = 11;
	localparam int CS_EN = 15;
	localparam int CS_CNT_LO = 16;
	localparam logic [1:0] KIND_ISO = 2'h1;

	// Timing: idle time before suspend, and length of driven resume signalling.
	localparam int SUSPEND_IDLE_US = 3000;
	localparam int RESUME_DRIVE_US = 10000;
	localparam int SUSPEND_CYCLES = SUSPEND_IDLE_US * CLK_MHZ;
	localparam int RESUME_CYCLES = RESUME_DRIVE_US * CLK_MHZ;
	localparam int CNT_W = 20;

	typedef enum logic [1:0] {PWR_ACTIVE, PWR_SUSPEND, PWR_RESUME} ues_pwr_t;

	// Events reported by the serial engine, one-cycle pulses except bus_reset (level).
	typedef struct packed {
		logic bus_activity;
		logic resume_seen;
		logic sof_seen;
		logic bus_reset;
		logic [NUM_EP-1:0] in_acked;
		logic [NUM_EP-1:0] bank0_stored;
		logic [NUM_EP-1:0] bank1_stored;
		logic [NUM_EP-1:0] setup_stored;
		logic [NUM_EP-1:0] stall_acked;
		logic [NUM_EP-1:0] crc_error;
		logic [10:0] rx_count;
	} ues_link_ev_t;

	// Controls handed to the serial engine.
	typedef struct packed {
		logic suspended;
		logic drive_resume;
		logic [NUM_EP-1:0] ep_enabled;
		logic [NUM_EP-1:0] ep_halt;
		logic [NUM_EP-1:0] tx_ready;
		logic [NUM_EP-1:0] out_accept;
		logic [NUM_EP-1:0] fifo_clear;
		logic [NUM_EP-1:0] data_toggle;
	} ues_link_ctl_t;

	typedef struct packed {
		logic tx_complete;
		logic rx_bank0_full;
		logic setup_received;
		logic stall_acked;
		logic tx_packet_ready;
		logic force_halt;
		logic rx_bank1_full;
		logic dir;
		logic [2:0] endpoint_kind;
		logic data_toggle;
		logic endpoint_enable;
		logic [10:0] rx_byte_count;
	} ues_ep_t;

	typedef struct packed {
		ues_ep_t [NUM_EP-1:0] ep;
		logic [13:8] bus_flags;
		logic [31:0] mask;
		logic [NUM_EP-1:0] ep_rst;
		logic rwe;
		ues_pwr_t pwr;
		logic [CNT_W-1:0] cnt;
		logic wake_s1;
		logic wake_s2;
		logic wake_s3;
		logic brst_prev;
		logic wr_pend;
		logic [11:0] wr_addr;
		logic [31:0] rdata;
		logic irq;
	} ues_state_t;

endpackage

// ==== logic/ues_endpoint_status.sv ====
// USB device endpoint status block: bus-event flags, endpoint FIFO reset and per-endpoint
// control/status, reached over AHB-Lite with zero wait states.
// Assumes a serial engine that reports bus and packet events synchronous to core_clk.
// Contract
// RL1: endpoint status bit is high while any of its five cause flags is set.
// RL2: after 3 ms without bus activity set suspend flag and enter suspend.
// RL3: set bus resume flag when host resume signalling is seen.
// RL4: in suspend, a rising wake request edge sets the external wake flag.
// RL5: with remote wake enabled, a wake request in suspend drives resume signalling.
// RL6: set frame start flag on every start-of-frame token.
// RL7: set bus reset done flag at end of reset; endpoint 0 becomes enabled.
// RL8: set host wake flag on host resume or reset; it holds until cleared.
// RL9: writing ones to clear register bits 8 to 13 clears those flags.
// RL10: endpoint reset bit zeroes FIFO pointers, byte count and data toggle.
// RL11: endpoint reset leaves the endpoint's control/status flags alone.
// RL12: firmware writes the endpoint reset bit back to zero afterwards.
// RL13: transmit complete set on acknowledged IN; write 0 clears, 1 ignored.
// RL14: bank 0 flag set on stored OUT packet; write 0 releases bank.
// RL15: firmware reads the byte count worth of data, then clears bank 0.
// RL16: setup flag set on valid SETUP packet; write 0 clears it.
// RL17: while setup flag is set, further OUT data is refused.
// RL18: stall flag set when host acknowledges STALL; write 0 clears it.
// RL19: on isochronous endpoints the same bit reports a CRC error.
// RL20: transmit ready set by firmware write 1, cleared once packet is sent.
// RL21: firmware checks transmit ready clear, fills FIFO, sets it, awaits completion.
// RL22: eight endpoints, each with status, reset bit and interrupt bit.
// RL23: bank 1 flag set on packet stored in bank 1; write 0 releases.
// RL24: received byte count is 11 bits, bytes of the last received packet.
// RL25: writing 1 to force halt makes the endpoint answer with STALL.
// RL26: interrupt output is OR of masked status bits, updated every cycle.
//
// Our own choices: the register offsets and the AHB-Lite slave port.
module ues_endpoint_status
	import ues_pkg::*;
#(
	parameter int SUSPEND_CYC = SUSPEND_CYCLES,
	parameter int RESUME_CYC = RESUME_CYCLES
)
(
	input wire logic core_clk, // Core clock, 100 MHz.
	input wire logic reset_n, // Asynchronous reset, active low.
	input wire logic hsel, // AHB slave select.
	input wire logic [31:0] haddr, // AHB address.
	input wire logic [1:0] htrans, // AHB transfer type.
	input wire logic hwrite, // AHB write strobe.
	input wire logic [2:0] hsize, // AHB size, only words are used.
	input wire logic [31:0] hwdata, // AHB write data.
	input wire logic hready, // AHB bus ready.
	output logic hreadyout, // AHB slave ready, always high.
	output logic hresp, // AHB response, always OKAY.
	output logic [31:0] hrdata, // AHB read data.
	input wire logic wake_req, // External wake request, asynchronous.
	input wire ues_link_ev_t link_ev, // Events from the serial engine.
	output ues_link_ctl_t link_ctl, // Controls to the serial engine.
	output logic irq // Port interrupt, active high.
);

	ues_state_t s_q;
	ues_state_t s_d;
	logic [NUM_EP-1:0] ep_irq;
	logic [31:0] status_word;

	localparam logic [CNT_W-1:0] SUSP_LAST = CNT_W'(SUSPEND_CYC - 1);
	localparam logic [CNT_W-1:0] RES_LAST = CNT_W'(RESUME_CYC - 1);

	function automatic logic csr_hit(input logic [11:0] addr, input int idx);
		csr_hit = (addr == OFF_CSR0 + 12'(idx * 4));
	endfunction

	function automatic logic [31:0] csr_word(input ues_ep_t e);
		logic [31:0] w;
		w = '0;
		w[CS_TXC] = e.tx_complete;
		w[CS_BK0] = e.rx_bank0_full;
		w[CS_SETUP] = e.setup_received;
		w[CS_STALL] = e.stall_acked;
		w[CS_TXRDY] = e.tx_packet_ready;
		w[CS_BK1] = e.rx_bank1_full;
		w[CS_DIR] = e.dir;
		w[CS_KIND_LO +: 3] = e.endpoint_kind;
		w[CS_TGL] = e.data_toggle;
		w[CS_EN] = e.endpoint_enable;
		w[CS_CNT_LO +: 11] = e.rx_byte_count;
		csr_word = w;
	endfunction

	// RL1 endpoint interrupt bits
	always_comb
	begin
		for (int i = 0; i < NUM_EP; i++)
		begin
			ep_irq[i] = s_q.ep[i].tx_complete | s_q.ep[i].rx_bank0_full
				| s_q.ep[i].rx_bank1_full | s_q.ep[i].setup_received
				| s_q.ep[i].stall_acked;
		end
		status_word = '0;
		status_word[NUM_EP-1:0] = ep_irq;
		status_word[13:8] = s_q.bus_flags;
	end

	always_comb
	begin
		logic ap;
		logic wr;
		logic wake_edge;
		logic brst_end;
		logic iso;
		logic [31:0] w;
		ap = 1'b0;
		wr = 1'b0;
		wake_edge = 1'b0;
		brst_end = 1'b0;
		iso = 1'b0;
		w = hwdata;
		s_d = s_q;

		// Address phase is latched; writes commit in the data phase when hwdata stands.
		ap = hsel & htrans[1] & hready;
		s_d.wr_pend = ap & hwrite;
		s_d.wr_addr = haddr[11:0];
		if (ap && !hwrite)
		begin
			s_d.rdata = '0;
			case (haddr[11:0])
				OFF_MASK: s_d.rdata = s_q.mask;
				OFF_STATUS: s_d.rdata = status_word;
				OFF_EPRST: s_d.rdata[NUM_EP-1:0] = s_q.ep_rst;
				OFF_CTRL: s_d.rdata[CTRL_RWE] = s_q.rwe;
				default:
				begin
					for (int i = 0; i < NUM_EP; i++)
					begin
						if (csr_hit(haddr[11:0], i))
						begin
							s_d.rdata = csr_word(s_q.ep[i]);
						end
					end
				end
			endcase
		end
		wr = s_q.wr_pend;

		if (wr && s_q.wr_addr == OFF_MASK)
		begin
			s_d.mask = hwdata & 32'h0000_3fff;
		end
		if (wr && s_q.wr_addr == OFF_EPRST)
		begin
			s_d.ep_rst = hwdata[NUM_EP-1:0];
		end
		if (wr && s_q.wr_addr == OFF_CTRL)
		begin
			s_d.rwe = hwdata[CTRL_RWE];
		end
		// RL9 write one to clear
		if (wr && s_q.wr_addr == OFF_CLEAR)
		begin
			s_d.bus_flags = s_q.bus_flags & ~hwdata[13:8];
		end

		// The wake input is asynchronous; only the second and third stages feed logic.
		s_d.wake_s1 = wake_req;
		s_d.wake_s2 = s_q.wake_s1;
		s_d.wake_s3 = s_q.wake_s2;
		wake_edge = s_q.wake_s2 & ~s_q.wake_s3;
		s_d.brst_prev = link_ev.bus_reset;
		brst_end = s_q.brst_prev & ~link_ev.bus_reset;

		// Flag sets come after the clear so an event in the clearing cycle is kept.
		case (s_q.pwr)
			PWR_ACTIVE:
			begin
				if (link_ev.bus_activity || link_ev.bus_reset)
				begin
					s_d.cnt = '0;
				end
				// RL2 idle timeout
				else if (s_q.cnt == SUSP_LAST)
				begin
					s_d.cnt = '0;
					s_d.pwr = PWR_SUSPEND;
					s_d.bus_flags[ST_SUSP] = 1'b1;
				end
				else
				begin
					s_d.cnt = s_q.cnt + 1'b1;
				end
			end
			PWR_SUSPEND:
			begin
				s_d.cnt = '0;
				if (link_ev.bus_activity || link_ev.resume_seen || link_ev.bus_reset)
				begin
					s_d.pwr = PWR_ACTIVE;
				end
				// RL4 external wake
				else if (wake_edge)
				begin
					s_d.bus_flags[ST_EXT] = 1'b1;
					// RL5 remote wake
					if (s_q.rwe)
					begin
						s_d.pwr = PWR_RESUME;
					end
				end
			end
			PWR_RESUME:
			begin
				if (s_q.cnt == RES_LAST)
				begin
					s_d.cnt = '0;
					s_d.pwr = PWR_ACTIVE;
				end
				else
				begin
					s_d.cnt = s_q.cnt + 1'b1;
				end
			end
			default:
			begin
				s_d.cnt = '0;
				s_d.pwr = PWR_ACTIVE;
			end
		endcase

		// RL3 host resume
		if (link_ev.resume_seen)
		begin
			s_d.bus_flags[ST_RSM] = 1'b1;
		end
		// RL6 frame start
		if (link_ev.sof_seen)
		begin
			s_d.bus_flags[ST_SOF] = 1'b1;
		end
		// RL8 host wake
		if (link_ev.resume_seen || (link_ev.bus_reset && !s_q.brst_prev))
		begin
			s_d.bus_flags[ST_WAKE] = 1'b1;
		end
		// RL7 end of bus reset
		if (brst_end)
		begin
			s_d.bus_flags[ST_BRST] = 1'b1;
			s_d.ep[0].endpoint_enable = 1'b1;
		end

		// RL22 eight endpoints
		for (int i = 0; i < NUM_EP; i++)
		begin
			iso = (s_q.ep[i].endpoint_kind[1:0] == KIND_ISO);
			if (wr && csr_hit(s_q.wr_addr, i))
			begin
				// RL13 clear on zero
				if (!w[CS_TXC])
				begin
					s_d.ep[i].tx_complete = 1'b0;
				end
				// RL14 bank 0 release
				if (!w[CS_BK0])
				begin
					s_d.ep[i].rx_bank0_full = 1'b0;
				end
				// RL16 setup clear
				if (!w[CS_SETUP])
				begin
					s_d.ep[i].setup_received = 1'b0;
				end
				// RL18 stall flag clear
				if (!w[CS_STALL])
				begin
					s_d.ep[i].stall_acked = 1'b0;
				end
				// RL23 bank 1 release
				if (!w[CS_BK1])
				begin
					s_d.ep[i].rx_bank1_full = 1'b0;
				end
				// RL20 firmware sets ready
				if (w[CS_TXRDY])
				begin
					s_d.ep[i].tx_packet_ready = 1'b1;
				end
				// RL25 force halt
				if (w[CS_HALT])
				begin
					s_d.ep[i].force_halt = 1'b1;
				end
				s_d.ep[i].dir = w[CS_DIR];
				s_d.ep[i].endpoint_kind = w[CS_KIND_LO +: 3];
				s_d.ep[i].endpoint_enable = w[CS_EN];
			end
			// RL13 IN acknowledged
			if (link_ev.in_acked[i])
			begin
				s_d.ep[i].tx_complete = 1'b1;
				// RL20 device clears ready
				s_d.ep[i].tx_packet_ready = 1'b0;
				s_d.ep[i].data_toggle = ~s_q.ep[i].data_toggle;
			end
			// RL17 OUT refused during setup
			if (link_ev.bank0_stored[i] && !s_q.ep[i].setup_received)
			begin
				s_d.ep[i].rx_bank0_full = 1'b1;
				// RL24 byte count
				s_d.ep[i].rx_byte_count = link_ev.rx_count;
				s_d.ep[i].data_toggle = ~s_q.ep[i].data_toggle;
			end
			// RL23 bank 1 stored
			if (link_ev.bank1_stored[i] && !s_q.ep[i].setup_received)
			begin
				s_d.ep[i].rx_bank1_full = 1'b1;
				s_d.ep[i].rx_byte_count = link_ev.rx_count;
				s_d.ep[i].data_toggle = ~s_q.ep[i].data_toggle;
			end
			// RL16 setup stored
			if (link_ev.setup_stored[i])
			begin
				s_d.ep[i].setup_received = 1'b1;
				s_d.ep[i].rx_byte_count = link_ev.rx_count;
				s_d.ep[i].data_toggle = 1'b1;
			end
			// RL18 stall acknowledged
			if (!iso && link_ev.stall_acked[i])
			begin
				s_d.ep[i].stall_acked = 1'b1;
				s_d.ep[i].force_halt = 1'b0;
			end
			// RL19 isochronous CRC error
			if (iso && link_ev.crc_error[i])
			begin
				s_d.ep[i].stall_acked = 1'b1;
			end
			// RL10 endpoint reset; RL11 flags are left as they are
			if (s_q.ep_rst[i])
			begin
				s_d.ep[i].rx_byte_count = '0;
				s_d.ep[i].data_toggle = 1'b0;
			end
		end

		// RL26 masked interrupt
		s_d.irq = |(status_word & s_q.mask);
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_q <= '0;
			s_q.mask <= MASK_RESET;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_q.rdata;
	assign irq = s_q.irq;

	always_comb
	begin
		link_ctl.suspended = (s_q.pwr == PWR_SUSPEND);
		link_ctl.drive_resume = (s_q.pwr == PWR_RESUME);
		for (int i = 0; i < NUM_EP; i++)
		begin
			link_ctl.ep_enabled[i] = s_q.ep[i].endpoint_enable;
			link_ctl.ep_halt[i] = s_q.ep[i].force_halt;
			link_ctl.tx_ready[i] = s_q.ep[i].tx_packet_ready;
			// RL17 OUT accept gate
			link_ctl.out_accept[i] = s_q.ep[i].endpoint_enable
				& ~s_q.ep[i].setup_received & ~s_q.ep_rst[i];
			// RL10 FIFO pointer clear; RL12 held until firmware writes zero
			link_ctl.fifo_clear[i] = s_q.ep_rst[i];
			link_ctl.data_toggle[i] = s_q.ep[i].data_toggle;
		end
	end

endmodule // ues_endpoint_status

// ==== bench/ues_endpoint_status_chk.sv ====
// Checker for the endpoint status block, bound to the ports of its top module.
// Assumes the bench keeps mask bit 9 set and leaves endpoint 0 alone just after a bus reset.
module ues_endpoint_status_chk
	import ues_pkg::*;
#(
	parameter int SUSPEND_CYC = SUSPEND_CYCLES,
	parameter int RESUME_CYC = RESUME_CYCLES
)
(
	input wire logic core_clk, // Clock.
	input wire logic reset_n, // Reset, active low.
	input wire logic hsel, // Select.
	input wire logic [31:0] haddr, // Address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write.
	input wire logic [2:0] hsize, // Size.
	input wire logic [31:0] hwdata, // Write data.
	input wire logic hready, // Bus ready.
	input wire logic hreadyout, // Slave ready.
	input wire logic hresp, // Response.
	input wire logic [31:0] hrdata, // Read data.
	input wire logic wake_req, // Wake request.
	input wire ues_link_ev_t link_ev, // Link events.
	input wire ues_link_ctl_t link_ctl, // Link controls.
	input wire logic irq // Interrupt.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [CNT_W-1:0] idle_q;
	logic [CNT_W-1:0] idle_d;
	// Consecutive quiet cycles, the yardstick for suspend entry.
	always_comb idle_d = (link_ev.bus_activity || link_ev.bus_reset) ? '0 : idle_q + 1'b1;
	always_ff @(posedge core_clk or negedge reset_n)
		if (!reset_n)
			idle_q <= '0;
		else
			idle_q <= idle_d;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	sequence s_rst_end;
		$fell(link_ev.bus_reset);
	endsequence
	property p_okay; hreadyout && !hresp; endproperty
	property p_ack; |link_ev.in_acked |=> (link_ctl.tx_ready & $past(link_ev.in_acked)) == '0;
	endproperty
	property p_tgl; (link_ctl.fifo_clear & $past(link_ctl.fifo_clear)
		& (link_ctl.data_toggle | link_ctl.out_accept)) == '0; endproperty
	property p_setup; |link_ev.setup_stored |=>
		(link_ctl.out_accept & $past(link_ev.setup_stored)) == '0; endproperty
	property p_rsm; link_ev.resume_seen |-> ##2 irq; endproperty
	property p_susp; $rose(link_ctl.suspended) |-> idle_q >= SUSPEND_CYC - 1; endproperty
	property p_wake; $rose(link_ctl.drive_resume) |-> $past(link_ctl.suspended); endproperty
	property p_brst; s_rst_end |-> ##[1:2] link_ctl.ep_enabled[0]; endproperty
	a_okay: assert property (p_okay) else $error("bus answer not ready and okay");
	a_ack: assert property (p_ack) else $error("send ready kept after ack");
	a_tgl: assert property (p_tgl) else $error("toggle or accept in fifo reset");
	a_setup: assert property (p_setup) else $error("out accepted with setup");
	a_rsm: assert property (p_rsm) else $error("no irq after resume");
	a_susp: assert property (p_susp) else $error("suspend too early");
	a_wake: assert property (p_wake) else $error("resume driven while awake");
	a_brst: assert property (p_brst) else $error("endpoint 0 off after reset");
endmodule // ues_endpoint_status_chk

bind ues_endpoint_status ues_endpoint_status_chk #(.SUSPEND_CYC(SUSPEND_CYC),
	.RESUME_CYC(RESUME_CYC)) chk_inst (.core_clk(core_clk), .reset_n(reset_n),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .wake_req(wake_req), .link_ev(link_ev), .link_ctl(link_ctl),
	.irq(irq));

// ==== bench/ues_host_model.sv ====
// Host and serial engine model: turns bench requests into one-cycle link pulses.
// Assumes the bench holds each request for one cycle, except bus_reset, which it holds as a level for several.
module ues_host_model
	import ues_pkg::*;
(
	input wire logic core_clk, // Clock.
	input wire logic reset_n, // Reset, active low.
	input wire ues_link_ev_t req, // Requested events.
	input wire ues_link_ctl_t link_ctl, // Controls from the device.
	output ues_link_ev_t link_ev // Events to the device.
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge core_clk or negedge reset_n)
		if (!reset_n)
			link_ev <= '0;
		else
		begin
			link_ev <= req;
			link_ev.in_acked <= req.in_acked & link_ctl.tx_ready;
			link_ev.bus_activity <= |req;
			// Count is junk outside a stored pulse.
			if (!(|req))
				link_ev.rx_count <= ~link_ev.rx_count;
		end
endmodule // ues_host_model

// ==== bench/ues_endpoint_status_test.sv ====
// Self-checking bench for the endpoint status block, registers over AHB-Lite.
// Assumes one slave on the bus, so hreadyout feeds hready.
module ues_endpoint_status_test
	import ues_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SC = 20;
	localparam int RC = 10;
	localparam logic [11:0] C0 = OFF_CSR0;
	logic core_clk;
	logic reset_n;
	logic hsel;
	logic hwrite;
	logic hready;
	logic hreadyout;
	logic hresp;
	logic irq;
	logic wake_req;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] q;
	ues_link_ev_t req;
	ues_link_ev_t link_ev;
	ues_link_ev_t e;
	ues_link_ctl_t link_ctl;
	int err_total;
	int n_tests;
	assign hready = hreadyout;
	always #5 core_clk = ~core_clk;
	ues_endpoint_status #(.SUSPEND_CYC(SC), .RESUME_CYC(RC)) ues_endpoint_status_inst (
		.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.wake_req(wake_req), .link_ev(link_ev), .link_ctl(link_ctl), .irq(irq));
	ues_host_model ues_host_model_inst (.core_clk(core_clk), .reset_n(reset_n),
		.req(req), .link_ctl(link_ctl), .link_ev(link_ev));
	task final_report;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] x);
		n_tests++;
		if (s !== x)
		begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, s, x);
		end
	endtask
	// Bounded wait for hready; a hang ends the run.
	task rdy;
		int n;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (hready !== 1'b1 && n < 20);
		if (hready !== 1'b1)
		begin
			err_total++;
			final_report;
		end
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		q = hrdata;
	endtask
	task rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
		bus(1'b0, a, 32'h0);
		chk(q & m, x);
	endtask
	task ev(input ues_link_ev_t v);
		req <= v;
		@(posedge core_clk);
		req <= '0;
		repeat (3) @(posedge core_clk);
	endtask
	initial
	begin
		core_clk = 1'b0;
		reset_n = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata, wake_req} = '0;
		hsize = 3'h2;
		req = '0;
		err_total = 0;
		n_tests = 0;
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		rc(OFF_MASK, 32'hffff_ffff, MASK_RESET);
		rc(OFF_CLEAR, 32'hffff_ffff, 32'h0);
		for (int i = 0; i < NUM_EP; i++)
			rc(C0 + 12'(4 * i), 32'hffff_ffff, 32'h0);
		$display("reset values done");
		rc(C0 + 12'h4, 32'h10, 32'h0);
		bus(1'b1, C0 + 12'h4, 32'h10);
		rc(C0 + 12'h4, 32'h11, 32'h10);
		e = '0;
		e.in_acked[1] = 1'b1;
		ev(e);
		rc(C0 + 12'h4, 32'h11, 32'h1);
		rc(OFF_STATUS, 32'hff, 32'h2);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, OFF_MASK, 32'h202);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, C0 + 12'h4, 32'h1);
		rc(C0 + 12'h4, 32'h1, 32'h1);
		bus(1'b1, C0 + 12'h4, 32'h0);
		rc(OFF_STATUS, 32'hff, 32'h0);
		bus(1'b1, OFF_MASK, MASK_RESET);
		$display("transmit done");
		e = '0;
		e.bank0_stored[2] = 1'b1;
		e.rx_count = 11'h7ff;
		ev(e);
		rc(C0 + 12'h8, 32'h07ff_0002, 32'h07ff_0002);
		bus(1'b1, OFF_EPRST, 32'h4);
		rc(OFF_EPRST, 32'hffff_ffff, 32'h4);
		chk({31'h0, link_ctl.fifo_clear[2]}, 32'h1);
		rc(C0 + 12'h8, 32'h07ff_0802, 32'h2);
		bus(1'b1, OFF_EPRST, 32'h0);
		bus(1'b1, C0 + 12'h8, 32'h0);
		chk({31'h0, link_ctl.fifo_clear[2]}, 32'h0);
		rc(C0 + 12'h8, 32'h2, 32'h0);
		$display("receive and fifo reset done");
		bus(1'b1, C0, 32'h8000);
		e = '0;
		e.setup_stored[0] = 1'b1;
		ev(e);
		rc(C0, 32'h806, 32'h804);
		chk({31'h0, link_ctl.out_accept[0]}, 32'h0);
		e = '0;
		e.bank0_stored[0] = 1'b1;
		ev(e);
		rc(C0, 32'h6, 32'h4);
		bus(1'b1, C0, 32'h8000);
		rc(C0, 32'h4, 32'h0);
		chk({31'h0, link_ctl.out_accept[0]}, 32'h1);
		bus(1'b1, C0, 32'h0);
		$display("setup done");
		bus(1'b1, C0 + 12'hc, 32'h20);
		@(posedge core_clk);
		chk({31'h0, link_ctl.ep_halt[3]}, 32'h1);
		rc(C0 + 12'hc, 32'h20, 32'h0);
		e = '0;
		e.stall_acked[3] = 1'b1;
		ev(e);
		rc(C0 + 12'hc, 32'h8, 32'h8);
		chk({31'h0, link_ctl.ep_halt[3]}, 32'h0);
		bus(1'b1, C0 + 12'hc, 32'h0);
		rc(C0 + 12'hc, 32'h8, 32'h0);
		bus(1'b1, C0 + 12'h10, 32'h100);
		e = '0;
		e.stall_acked[4] = 1'b1;
		ev(e);
		rc(C0 + 12'h10, 32'h8, 32'h0);
		e = '0;
		e.crc_error[4] = 1'b1;
		ev(e);
		rc(C0 + 12'h10, 32'h8, 32'h8);
		rc(OFF_STATUS, 32'h10, 32'h10);
		bus(1'b1, C0 + 12'h10, 32'h0);
		$display("stall and iso done");
		e = '0;
		e.sof_seen = 1'b1;
		e.resume_seen = 1'b1;
		ev(e);
		rc(OFF_STATUS, 32'h3e00, 32'h2a00);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, OFF_CLEAR, 32'h0800);
		rc(OFF_STATUS, 32'h3e00, 32'h2200);
		bus(1'b1, OFF_CLEAR, 32'h3f00);
		rc(OFF_STATUS, 32'h3e00, 32'h0);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		req.bus_reset <= 1'b1;
		repeat (4) @(posedge core_clk);
		req.bus_reset <= 1'b0;
		repeat (4) @(posedge core_clk);
		rc(OFF_STATUS, 32'h3000, 32'h3000);
		rc(C0, 32'h8000, 32'h8000);
		$display("bus events done");
		bus(1'b1, OFF_CTRL, 32'h1);
		bus(1'b1, OFF_CLEAR, 32'h3f00);
		repeat (SC + 5) @(posedge core_clk);
		rc(OFF_STATUS, 32'h0500, 32'h0100);
		chk({31'h0, link_ctl.suspended}, 32'h1);
		wake_req <= 1'b1;
		repeat (5) @(posedge core_clk);
		chk({31'h0, link_ctl.drive_resume}, 32'h1);
		rc(OFF_STATUS, 32'h0400, 32'h0400);
		repeat (RC + 5) @(posedge core_clk);
		chk({31'h0, link_ctl.drive_resume}, 32'h0);
		wake_req <= 1'b0;
		$display("suspend and wake done");
		final_report;
	end
endmodule // ues_endpoint_status_test
